// File: fcr_core.sv
`default_nettype none
module fcr_core (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Switching command and output stage.
  input  wire logic        pwm_in,
  output logic             gate_on_r,
  output logic             gate_tristate_r,
  // Protection comparators and monitors.
  input  wire logic        desaturation_detect,
  input  wire logic        overcurrent_detect,
  input  wire logic        overcurrent_sense_check,
  input  wire logic        external_enable_input,
  input  wire logic        output_stage_mismatch,
  input  wire logic        output_disable_pin,
  input  wire logic        uv_primary,
  input  wire logic        uv_secondary_pos,
  input  wire logic        uv_secondary_neg,
  input  wire logic        ov_secondary_pos,
  input  wire logic        negative_supply_overvoltage,
  input  wire logic        internal_fault,
  input  wire logic        gate_monitor_fault,
  input  wire logic        shoot_through_guard,
  input  wire logic        switch_sense,
  // Configuration.
  input  wire logic        neg_overvoltage_notify_only,
  input  wire logic        tristate_class_a_suppress,
  // Host control.
  input  wire logic        reactivate,
  input  wire logic        reinit,
  input  wire logic [15:0] flag_clear,
  // Self test control.
  input  wire logic        test_start,
  input  wire logic [2:0]  test_sel,
  input  wire logic        osc_tick,
  input  wire logic        secondary_digital_io,
  output logic             primary_digital_io_r,
  output logic             test_stim_r,
  output logic             test_busy_r,
  output logic             test_pass_r,
  // Status.
  output logic [15:0]      error_flags,
  output logic [1:0]       operating_mode_state,
  output logic             fast_fault_pin_b,
  output logic             slow_fault_pin_b,
  output logic             switch_state_r
);
  // ----------------------------------------------------------------------
  // Event classification
  // ----------------------------------------------------------------------
  // One bit per event source. The bit positions match the error flags, so
  // the host reads back exactly which supervision function tripped.
  // The shutdown categories are picked out of this vector by the masks.
  logic [15:0]        ev;
  // Self-test failure, raised only on the last cycle of a window.
  logic               test_fail;
  // Any unmasked category A or category B event in this cycle.
  logic               cat_a;
  logic               cat_b;
  fcr_pkg::fcr_state_t state_r;
  fcr_pkg::fcr_state_t state_nxt;
  logic [7:0]         test_cnt_r;
  logic [7:0]         osc_cnt_r;
  logic [2:0]         test_sel_r;
  logic               test_seen_r;

  // Gathers every event source into one vector.
  // Desaturation and overcurrent only count while the gate is driven on,
  // since both comparators have nothing to judge with the switch off.
  // The enable pin is inverted because a low level is the invalid one.
  always_comb begin
    ev = 16'h0000;
    ev[fcr_pkg::EV_DESATURATION_DETECT] = desaturation_detect & gate_on_r;
    ev[fcr_pkg::EV_OCP] = overcurrent_detect & gate_on_r;
    ev[fcr_pkg::EV_ENABLE] = ~external_enable_input;
    ev[fcr_pkg::EV_OSM] = output_stage_mismatch;
    ev[fcr_pkg::EV_TRISTATE] = output_disable_pin;
    ev[fcr_pkg::EV_UV_PRI] = uv_primary;
    ev[fcr_pkg::EV_UV_POS] = uv_secondary_pos;
    ev[fcr_pkg::EV_UV_NEG] = uv_secondary_neg;
    ev[fcr_pkg::EV_OV_POS] = ov_secondary_pos;
    ev[fcr_pkg::EV_OV_NEG] = negative_supply_overvoltage;
    ev[fcr_pkg::EV_INTERNAL] = internal_fault;
    ev[fcr_pkg::EV_GATE_MON] = gate_monitor_fault;
    ev[fcr_pkg::EV_SHOOT] = shoot_through_guard;
    ev[fcr_pkg::EV_OCP_SENSE] = overcurrent_sense_check;
    ev[fcr_pkg::EV_SELFTEST] = test_fail;
  end

  // Category A: tristate may be suppressed, flag is still raised.
  // The suppress bit only removes the tristate source from the shutdown
  // decision; the flag and the tristate itself are handled elsewhere.
  assign cat_a = |(ev & fcr_pkg::CAT_A_MASK
                   & ~({15'h0000, tristate_class_a_suppress}
                       << fcr_pkg::EV_TRISTATE));
  // Category B: negative overvoltage may be demoted to notify only.
  // Demoted, it changes neither the mode nor the slow fault pin, but its
  // flag still sets through the event vector.
  assign cat_b = |(ev & fcr_pkg::CAT_B_MASK
                   & ~({15'h0000, neg_overvoltage_notify_only}
                       << fcr_pkg::EV_OV_NEG));

  // ----------------------------------------------------------------------
  // Sticky error flags
  // ----------------------------------------------------------------------
  // One sticky flag per event bit. A set that lands in the same cycle as
  // the host's clear wins, so an event is never lost to a badly timed
  // clear; the host simply sees the flag again and clears it once more.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      fcr_flag u_flag (
        .clk    (clk),
        .rst_b  (rst_b),
        .set_i  (ev[gi]),
        .clr_i  (flag_clear[gi]),
        .flag_r (error_flags[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Operating state
  // ----------------------------------------------------------------------
  // B outranks A; category C never changes the state.
  // Reset leaves the block in the slow shutdown, so the host must run its
  // full initialisation before the first switching command is obeyed.
  // Category A is left by a reactivation pulse, category B only by a
  // reinitialisation pulse, and neither is taken while a cause persists.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fcr_pkg::FCR_RUN: begin
        if (cat_b) begin
          state_nxt = fcr_pkg::FCR_OFF_B;
        end else if (cat_a) begin
          state_nxt = fcr_pkg::FCR_OFF_A;
        end
      end
      fcr_pkg::FCR_OFF_A: begin
        if (cat_b) begin
          state_nxt = fcr_pkg::FCR_OFF_B;
        end else if (reactivate && !cat_a) begin
          state_nxt = fcr_pkg::FCR_RUN;
        end
      end
      fcr_pkg::FCR_OFF_B: begin
        if (reinit && !cat_b && !cat_a) begin
          state_nxt = fcr_pkg::FCR_RUN;
        end
      end
      default: begin
        state_nxt = fcr_pkg::FCR_OFF_B;
      end
    endcase
  end

  // Registers the operating state.
  // The state is read straight out as the operating mode. Unknown codes
  // fall back to the slow shutdown, the safest place to recover from.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= fcr_pkg::FCR_OFF_B;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign operating_mode_state = state_r;

  // ----------------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------------
  // Gate follows the command only in run; shutdown forces it off at once.
  // The shutdown term uses the live categories too, so the gate drops on
  // the very edge that samples the event, not one cycle later.
  // A running self test also holds the gate off.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gate_on_r <= 1'b0;
    end else if (state_r != fcr_pkg::FCR_RUN || cat_a || cat_b) begin
      gate_on_r <= 1'b0;
    end else if (test_busy_r) begin
      gate_on_r <= 1'b0;
    end else begin
      gate_on_r <= pwm_in;
    end
  end

  // Tristates the stage on the disable pin regardless of suppression.
  // The suppress bit only decides whether a shutdown follows, so the
  // stage is released from the pin even while the block keeps running.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gate_tristate_r <= 1'b0;
    end else begin
      gate_tristate_r <= output_disable_pin;
    end
  end

  // Reports the sensed switch state, notification only.
  // It never feeds back into the state machine or the gate.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      switch_state_r <= 1'b0;
    end else begin
      switch_state_r <= switch_sense;
    end
  end

  // Fault pins are low while the matching shutdown holds.
  // Both are decoded from the state register, so they do not glitch and
  // release on the edge that leaves the shutdown.
  assign fast_fault_pin_b = (state_r != fcr_pkg::FCR_OFF_A);
  assign slow_fault_pin_b = (state_r != fcr_pkg::FCR_OFF_B);

  // ----------------------------------------------------------------------
  // Intrusive self tests
  // ----------------------------------------------------------------------
  // Accepts a start only in shutdown, when the application is idle.
  // The window counter loads the fixed length and counts down to one; the
  // last cycle is the one on which the verdict is taken. A start during a
  // running window is ignored.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      test_busy_r <= 1'b0;
      test_sel_r <= fcr_pkg::TST_DESATURATION_DETECT;
      test_cnt_r <= 8'h00;
    end else if (!test_busy_r) begin
      if (test_start && state_r != fcr_pkg::FCR_RUN) begin
        test_busy_r <= 1'b1;
        test_sel_r <= test_sel;
        test_cnt_r <= fcr_pkg::TEST_WIN_CYC;
      end
    end else if (test_cnt_r == 8'h01) begin
      test_busy_r <= 1'b0;
      test_cnt_r <= 8'h00;
    end else begin
      test_cnt_r <= test_cnt_r - 8'h01;
    end
  end

  // Drives the stimulus and, for the channel test, the digital output.
  // Both lag the busy flag by one cycle, which the window length absorbs.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      test_stim_r <= 1'b0;
      primary_digital_io_r <= 1'b0;
    end else begin
      test_stim_r <= test_busy_r;
      primary_digital_io_r <= test_busy_r
                              && test_sel_r == fcr_pkg::TST_DIO;
    end
  end

  // Records whether the injected fault was seen, and counts oscillator ticks.
  // The tick counter saturates so that a runaway oscillator cannot wrap
  // round into the legal band. Both are cleared between windows.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      test_seen_r <= 1'b0;
      osc_cnt_r <= 8'h00;
    end else if (!test_busy_r) begin
      test_seen_r <= 1'b0;
      osc_cnt_r <= 8'h00;
    end else begin
      if (osc_tick && osc_cnt_r != 8'hFF) begin
        osc_cnt_r <= osc_cnt_r + 8'h01;
      end
      case (test_sel_r)
        fcr_pkg::TST_DESATURATION_DETECT: begin
          test_seen_r <= test_seen_r | desaturation_detect;
        end
        fcr_pkg::TST_OCP: begin
          test_seen_r <= test_seen_r | overcurrent_detect;
        end
        fcr_pkg::TST_UVLO: begin
          test_seen_r <= test_seen_r | uv_secondary_pos;
        end
        fcr_pkg::TST_OVLO: begin
          test_seen_r <= test_seen_r | ov_secondary_pos;
        end
        fcr_pkg::TST_DIO: begin
          test_seen_r <= test_seen_r | secondary_digital_io;
        end
        default: begin
          test_seen_r <= test_seen_r;
        end
      endcase
    end
  end

  // Judges the test on the last window cycle.
  // The clock test compares the tick count against its band; every other
  // test fails when its monitor never reported the injected fault. A
  // failure raises the self-test event and so its sticky flag.
  always_comb begin
    test_fail = 1'b0;
    if (test_busy_r && test_cnt_r == 8'h01) begin
      if (test_sel_r == fcr_pkg::TST_CLOCK) begin
        test_fail = (osc_cnt_r < fcr_pkg::OSC_MIN)
                    || (osc_cnt_r > fcr_pkg::OSC_MAX);
      end else begin
        test_fail = ~test_seen_r;
      end
    end
  end

  // Holds the verdict of the latest test.
  // A new start clears it, so a stale pass is never read as a fresh one.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      test_pass_r <= 1'b0;
    end else if (test_start && !test_busy_r) begin
      test_pass_r <= 1'b0;
    end else if (test_busy_r && test_cnt_r == 8'h01) begin
      test_pass_r <= ~test_fail;
    end
  end
endmodule // fcr_core
`default_nettype wire

// File: fcr_pkg.sv
`default_nettype none
package fcr_pkg;
  // ----------------------------------------------------------------------
  // Event vector layout and timing counts.
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_EV = 16;
  // Category A sources.
  localparam int unsigned EV_DESATURATION_DETECT = 0;
  localparam int unsigned EV_OCP = 1;
  localparam int unsigned EV_ENABLE = 2;
  localparam int unsigned EV_OSM = 3;
  localparam int unsigned EV_TRISTATE = 4;
  // Category B sources.
  localparam int unsigned EV_UV_PRI = 5;
  localparam int unsigned EV_UV_POS = 6;
  localparam int unsigned EV_UV_NEG = 7;
  localparam int unsigned EV_OV_POS = 8;
  localparam int unsigned EV_OV_NEG = 9;
  localparam int unsigned EV_INTERNAL = 10;
  // Category C sources.
  localparam int unsigned EV_GATE_MON = 11;
  localparam int unsigned EV_SHOOT = 12;
  localparam int unsigned EV_OCP_SENSE = 13;
  // Category D self-test failure.
  localparam int unsigned EV_SELFTEST = 14;
  localparam int unsigned EV_SPARE = 15;
  // Masks of the categories that shut the output down.
  localparam logic [15:0] CAT_A_MASK = 16'h001F;
  localparam logic [15:0] CAT_B_MASK = 16'h07E0;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  // Self-test selection codes.
  localparam logic [2:0] TST_DESATURATION_DETECT = 3'h0;
  localparam logic [2:0] TST_OCP = 3'h1;
  localparam logic [2:0] TST_UVLO = 3'h2;
  localparam logic [2:0] TST_OVLO = 3'h3;
  localparam logic [2:0] TST_CLOCK = 3'h4;
  localparam logic [2:0] TST_DIO = 3'h5;
  // Self-test window: the stimulus is held this long, 4000 ns.
  localparam int unsigned TEST_WIN_NS = 4000;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned TEST_WIN_CYC_I = TEST_WIN_NS / CLK_NS;
  localparam logic [7:0] TEST_WIN_CYC = 8'(TEST_WIN_CYC_I);
  // Oscillator plausibility limits in ticks per window.
  localparam logic [7:0] OSC_MIN = 8'h40;
  localparam logic [7:0] OSC_MAX = 8'h60;
  // Operating states.
  typedef enum logic [1:0] {
    FCR_RUN,
    FCR_OFF_A,
    FCR_OFF_B
  } fcr_state_t;
endpackage
`default_nettype wire

// File: fcr_flag.sv
`default_nettype none
// Sticky flag: hardware set wins over host clear.
module fcr_flag (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_b,
  // Set and clear.
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_r
);
  // Holds the flag until cleared, a new set in the clear cycle wins.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
    end else if (set_i) begin
      flag_r <= 1'b1;
    end else if (clr_i) begin
      flag_r <= 1'b0;
    end
  end
endmodule // fcr_flag
`default_nettype wire

// File: fcr_monitor.sv
`default_nettype none
// ----------------------------------------------------------------------
// Checker on the fault response ports.
// ----------------------------------------------------------------------
module fcr_monitor (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_b,
  // Watched ports.
  input wire logic        gate_on_r,
  input wire logic        desaturation_detect,
  input wire logic        overcurrent_detect,
  input wire logic        reactivate,
  input wire logic        reinit,
  input wire logic [15:0] flag_clear,
  input wire logic [15:0] error_flags,
  input wire logic [1:0]  operating_mode_state,
  input wire logic        fast_fault_pin_b,
  input wire logic        slow_fault_pin_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks use clk and are muted while reset is low.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  desaturation_detect_trip_a: assert property (
    gate_on_r && desaturation_detect |=> operating_mode_state != 2'h0
    && !gate_on_r && error_flags[0]) else $error("desaturation_detect did not trip");
  ocp_trip_a: assert property (
    gate_on_r && overcurrent_detect |=> operating_mode_state != 2'h0
    && !gate_on_r && error_flags[1]) else $error("ocp did not trip");
  flags_stick_a: assert property (
    1'b1 |=> ($past(error_flags) & ~$past(flag_clear) & ~error_flags)
    == 16'h0000) else $error("flag lost without clear");
  fast_pin_a: assert property (
    fast_fault_pin_b == (operating_mode_state != 2'h1))
    else $error("fast fault pin wrong");
  slow_pin_a: assert property (
    slow_fault_pin_b == (operating_mode_state != 2'h2))
    else $error("slow fault pin wrong");
  gate_safe_a: assert property (
    operating_mode_state != 2'h0 |-> !gate_on_r)
    else $error("gate on while shut down");
  a_hold_a: assert property (
    operating_mode_state == 2'h1 && !reactivate |=>
    operating_mode_state != 2'h0) else $error("left off_A alone");
  b_hold_a: assert property (
    operating_mode_state == 2'h2 && !reinit |=>
    operating_mode_state == 2'h2) else $error("left off_B alone");
  // Main scenarios reached.
  cover property (operating_mode_state == 2'h1 ##1 operating_mode_state == 2'h0);
  cover property (operating_mode_state == 2'h2 ##1 operating_mode_state == 2'h0);
  cover property (error_flags[9] && operating_mode_state == 2'h0);
endmodule // fcr_monitor
bind fcr_core fcr_monitor fcr_monitor_i (
  .clk                  (clk),
  .rst_b                (rst_b),
  .gate_on_r            (gate_on_r),
  .desaturation_detect  (desaturation_detect),
  .overcurrent_detect   (overcurrent_detect),
  .reactivate           (reactivate),
  .reinit               (reinit),
  .flag_clear           (flag_clear),
  .error_flags          (error_flags),
  .operating_mode_state (operating_mode_state),
  .fast_fault_pin_b     (fast_fault_pin_b),
  .slow_fault_pin_b     (slow_fault_pin_b)
);
`default_nettype wire

// File: fcr_host.sv
`default_nettype none
// ----------------------------------------------------------------------
// Power switch and far digital pin seen by the driver.
// ----------------------------------------------------------------------
module fcr_host (
  // Clock.
  input wire logic clk,
  // Drive from the block.
  input wire logic gate_on_r,
  input wire logic primary_digital_io_r,
  // Answers.
  output var logic switch_sense = 1'b0,
  output var logic secondary_digital_io = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // The switch follows its gate one cycle later.
  always_ff @(posedge clk) begin
    switch_sense <= gate_on_r;
  end
  // The isolated channel returns through the far side.
  always_ff @(posedge clk) begin
    secondary_digital_io <= primary_digital_io_r;
  end
endmodule // fcr_host
`default_nettype wire

// File: tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals.
  // ----------------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        pwm_in = 1'b0;
  logic [13:0] ev = 14'h0000;
  logic        neg_notify = 1'b0;
  logic        tri_sup = 1'b0;
  logic        reactivate = 1'b0;
  logic        reinit = 1'b0;
  logic [15:0] flag_clear = 16'h0000;
  logic        test_start = 1'b0;
  logic [2:0]  test_sel = 3'h0;
  logic        osc_tick = 1'b0;
  logic        gate_on_r, gate_tristate_r, pio, sio, sense, test_busy_r;
  logic        test_pass_r, fast_b, slow_b, switch_state_r, stim;
  logic [15:0] error_flags;
  logic [1:0]  operating_mode_state;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  // Clock of 40 ns.
  always #20 clk = ~clk;
  fcr_core fcr_core_i (.clk(clk), .rst_b(rst_b), .pwm_in(pwm_in),
    .gate_on_r(gate_on_r), .gate_tristate_r(gate_tristate_r),
    .desaturation_detect(ev[0]), .overcurrent_detect(ev[1]),
    .external_enable_input(!ev[2]), .output_stage_mismatch(ev[3]),
    .output_disable_pin(ev[4]), .uv_primary(ev[5]),
    .uv_secondary_pos(ev[6]), .uv_secondary_neg(ev[7]),
    .ov_secondary_pos(ev[8]), .negative_supply_overvoltage(ev[9]),
    .internal_fault(ev[10]), .gate_monitor_fault(ev[11]),
    .shoot_through_guard(ev[12]), .overcurrent_sense_check(ev[13]),
    .switch_sense(sense), .neg_overvoltage_notify_only(neg_notify),
    .tristate_class_a_suppress(tri_sup), .reactivate(reactivate),
    .reinit(reinit), .flag_clear(flag_clear), .test_start(test_start),
    .test_sel(test_sel), .osc_tick(osc_tick),
    .secondary_digital_io(sio), .primary_digital_io_r(pio),
    .test_stim_r(stim), .test_busy_r(test_busy_r),
    .test_pass_r(test_pass_r),
    .error_flags(error_flags), .operating_mode_state(operating_mode_state),
    .fast_fault_pin_b(fast_b), .slow_fault_pin_b(slow_b),
    .switch_state_r(switch_state_r));
  fcr_host fcr_host_i (.clk(clk), .gate_on_r(gate_on_r),
    .primary_digital_io_r(pio), .switch_sense(sense),
    .secondary_digital_io(sio));
  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  // Counts a comparison and reports a miss.
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      stop_test;
    end
  end
  // Trips one source while switching, then recovers the block.
  task ev_case(input int i, input logic [1:0] exp);
    @(posedge clk) pwm_in <= 1'b1;
    repeat (3) @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk) ev[i] <= 1'b0;
    #1 chk(operating_mode_state === exp, "category");
    chk(error_flags[i] === 1'b1, "flag set");
    chk(switch_state_r === 1'b1, "switch state");
    chk(gate_tristate_r === (i == 4), "tristate");
    if (i != 4) chk(gate_on_r === (exp == 2'h0), "gate");
    repeat (2) @(posedge clk);
    #1 chk(operating_mode_state === exp, "held off");
    @(posedge clk) reactivate <= 1'b1;
    @(posedge clk) reactivate <= 1'b0;
    #1 chk(operating_mode_state === (exp == 2'h2 ? exp : 2'h0), "react");
    @(posedge clk) reinit <= 1'b1;
    pwm_in <= 1'b0;
    flag_clear <= 16'hFFFF;
    @(posedge clk) reinit <= 1'b0;
    flag_clear <= 16'h0000;
    #1 chk(operating_mode_state === 2'h0, "reinit");
    chk(error_flags === 16'h0000, "cleared");
  endtask
  // Runs one self test and judges its verdict.
  task self_test(input logic [2:0] sel, input int per, input logic ok);
    @(posedge clk) test_sel <= sel;
    test_start <= 1'b1;
    @(posedge clk) test_start <= 1'b0;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk) osc_tick <= (k % 4) < per;
      #1 if (!test_busy_r) break;
    end
    chk(test_busy_r === 1'b0, "test end");
    chk(stim === 1'b1, "stimulus held");
    chk(test_pass_r === ok, "verdict");
    chk(error_flags[14] === !ok, "fail flag");
    @(posedge clk) flag_clear <= 16'h4000;
    @(posedge clk) flag_clear <= 16'h0000;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    #1 chk(operating_mode_state === 2'h2 && !slow_b && fast_b, "reset");
    chk(error_flags === fcr_pkg::FLAGS_RST, "flags at reset");
    @(posedge clk) rst_b <= 1'b1;
    @(posedge clk) reinit <= 1'b1;
    @(posedge clk) reinit <= 1'b0;
    #1 chk(operating_mode_state === 2'h0, "run");
    for (int i = 0; i < 14; i++) begin
      ev_case(i, fcr_pkg::CAT_A_MASK[i] ? 2'h1 :
        (fcr_pkg::CAT_B_MASK[i] ? 2'h2 : 2'h0));
    end
    neg_notify <= 1'b1;
    ev_case(9, 2'h0);
    tri_sup <= 1'b1;
    ev_case(4, 2'h0);
    @(posedge clk) test_start <= 1'b1;
    @(posedge clk) test_start <= 1'b0;
    #1 chk(test_busy_r === 1'b0, "test in run");
    @(posedge clk) ev[5] <= 1'b1;
    @(posedge clk) ev[5] <= 1'b0;
    self_test(fcr_pkg::TST_CLOCK, 3, 1'b1);
    self_test(fcr_pkg::TST_CLOCK, 4, 1'b0);
    self_test(fcr_pkg::TST_DIO, 3, 1'b1);
    ev[0] <= 1'b1;
    self_test(fcr_pkg::TST_DESATURATION_DETECT, 3, 1'b1);
    ev <= 14'h0002;
    self_test(fcr_pkg::TST_OCP, 3, 1'b1);
    ev <= 14'h0040;
    self_test(fcr_pkg::TST_UVLO, 3, 1'b1);
    ev <= 14'h0100;
    self_test(fcr_pkg::TST_OVLO, 3, 1'b1);
    ev <= 14'h0000;
    self_test(fcr_pkg::TST_OVLO, 3, 1'b0);
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
